// File: src/efr_top.sv
// Earth-fault control input routing: switchgroups, output matrix, bus slave
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "efr_cfg.svh"

module efr_top (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic               wb_we_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   output logic                    irq,
   input  wire logic               blocking_input_one,
   input  wire logic               blocking_input_two,
   input  wire logic               remote_reset_input,
   input  wire logic [2:0]         stage_start,
   input  wire logic [2:0]         stage_trip,
   input  wire logic               transient_activated,
   input  wire logic [7:0]         resid_voltage_pct,
   input  wire logic [7:0]         neutral_current_pct,
   input  wire logic signed [8:0]  phase_angle_deg,
   input  wire logic [7:0]         noise_pct,
   input  wire logic               transient_locating,
   output logic                    block_low_set_stage,
   output logic                    block_high_set_stage,
   output logic                    block_transient_stage,
   output logic [1:0]              characteristic_select,
   output logic                    second_bank_select,
   output logic                    indicator_reset,
   output logic                    relay_reset,
   output logic                    register_clear,
   output logic [3:0]              start_outputs,
   output logic [3:0]              trip_outputs,
   output logic [3:0]              display_digit_hi,
   output logic [3:0]              display_digit_mid,
   output logic [3:0]              display_digit_lo,
   output logic                    display_minus,
   output logic                    display_dash
);
   import efr_pkg::*;

   efr_state_t  q_ff;
   efr_state_t  nxt_q;
   logic [2:0]  ctl_in;
   logic [5:0]  stage_sig;
   logic [3:0]  route_start;
   logic [3:0]  route_trip;
   logic [7:0]  byte_adr;
   logic        req;
   logic        wr_now;
   logic [31:0] disp_word;
   logic [3:0]  dd_hi;
   logic [3:0]  dd_mid;
   logic [3:0]  dd_lo;
   logic        dd_minus;
   logic        dd_dash;

   // True when any active control input has the given switch set
   function automatic logic any_sel(input logic [2:0] act,
                                    input logic [2:0][7:0] sg,
                                    input int unsigned sw);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 3; i++) begin
         r = r | (act[i] & sg[i][sw]);
      end
      any_sel = r;
   endfunction

   // Checksum of one switchgroup from per-switch weights 1..128
   function automatic logic [7:0] cksum(input logic [7:0] sg);
      logic [7:0] s;
      s = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (sg[k]) begin
            s = s + 8'(1 << k);
         end
      end
      cksum = s;
   endfunction

   // Control inputs in switchgroup order
   assign ctl_in = {remote_reset_input, blocking_input_two, blocking_input_one};

   // Stage signals in routing group order: start then trip of each stage
   assign stage_sig = {stage_trip[2], stage_start[2], stage_trip[1],
                       stage_start[1], stage_trip[0], stage_start[0]};

   // Output matrix: switches 1..4 feed start outputs, 5..8 feed trip outputs
   genvar o;
   generate
      for (o = 0; o < 4; o++) begin : g_route
         logic [5:0] hit_s;
         logic [5:0] hit_t;
         for (genvar g = 0; g < 6; g++) begin : g_grp
            assign hit_s[g] = stage_sig[g] & q_ff.orsg[g][o];
            assign hit_t[g] = stage_sig[g] & q_ff.orsg[g][o + 4];
         end
         assign route_start[o] = |hit_s;
         assign route_trip[o] = |hit_t;
      end
   endgenerate

   // Bus handshake: ack one cycle after the request, write at the ack edge
   assign byte_adr = {wb_adr_i[7:2], 2'b00};
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_now = req & wb_we_i & q_ff.ack & wb_sel_i[0];

   assign disp_word = {18'h0, dd_dash, dd_minus, dd_hi, dd_mid, dd_lo};

   // Next state of the whole block
   always_comb begin
      logic       blk_low;
      logic       blk_high;
      logic       blk_tr;
      logic       swap;
      logic       bank_in;
      logic       rst_ind;
      logic       rst_rel;
      logic       rst_reg;
      logic [2:0] rise;
      logic [4:0] ev;
      logic [4:0] clr;
      blk_low = 1'b0;
      blk_high = 1'b0;
      blk_tr = 1'b0;
      swap = 1'b0;
      bank_in = 1'b0;
      rst_ind = 1'b0;
      rst_rel = 1'b0;
      rst_reg = 1'b0;
      rise = 3'h0;
      ev = 5'h00;
      clr = 5'h00;
      nxt_q = q_ff;

      // Blocking: a configured input blocks while it is active
      blk_low = any_sel(ctl_in, q_ff.cisg, `EFR_SW_BLK_LOW);
      blk_high = any_sel(ctl_in, q_ff.cisg, `EFR_SW_BLK_HIGH);
      // An already activated transient stage is left running
      blk_tr = any_sel(ctl_in, q_ff.cisg, `EFR_SW_BLK_TR) & ~transient_activated;
      nxt_q.blk_low = blk_low;
      nxt_q.blk_high = blk_high;
      nxt_q.blk_tr = blk_tr;

      // Characteristic swap flips the angle/sine-cosine bit only
      swap = any_sel(ctl_in, q_ff.cisg, `EFR_SW_SWAP) & q_ff.swap_en;
      nxt_q.char_eff = {q_ff.char_sel[1], q_ff.char_sel[0] ^ swap};

      // Bank: energized configured input, or the software bank bit
      bank_in = any_sel(ctl_in, q_ff.cisg, `EFR_SW_BANK);
      nxt_q.bank2 = bank_in | q_ff.sw_bank;

      // Resets act on activation, so a held input gives one pulse
      rise = ctl_in & ~q_ff.in_prev;
      nxt_q.in_prev = ctl_in;
      rst_reg = any_sel(rise, q_ff.cisg, `EFR_SW_RST_REG);
      rst_rel = any_sel(rise, q_ff.cisg, `EFR_SW_RST_REL) | rst_reg;
      rst_ind = any_sel(rise, q_ff.cisg, `EFR_SW_RST_IND) | rst_rel;
      nxt_q.ind_rst = rst_ind;
      nxt_q.rel_rst = rst_rel;
      nxt_q.reg_clr = rst_reg;

      // Output matrix result
      nxt_q.start_o = route_start;
      nxt_q.trip_o = route_trip;

      // Events for the sticky status register
      ev[`EFR_EV_IND] = rst_ind;
      ev[`EFR_EV_REL] = rst_rel;
      ev[`EFR_EV_REG] = rst_reg;
      ev[`EFR_EV_BLOCK] = (blk_low & ~q_ff.blk_low) | (blk_high & ~q_ff.blk_high)
                          | (blk_tr & ~q_ff.blk_tr);

      // Bus: answer every request, unmapped ones read zero
      nxt_q.ack = req & ~q_ff.ack;
      if (req & ~q_ff.ack) begin
         unique case (byte_adr)
            `EFR_OFS_CISG0:    nxt_q.rdat = {24'h000000, q_ff.cisg[0]};
            `EFR_OFS_CISG1:    nxt_q.rdat = {24'h000000, q_ff.cisg[1]};
            `EFR_OFS_CISG2:    nxt_q.rdat = {24'h000000, q_ff.cisg[2]};
            `EFR_OFS_ORSG0:    nxt_q.rdat = {24'h000000, q_ff.orsg[0]};
            `EFR_OFS_ORSG1:    nxt_q.rdat = {24'h000000, q_ff.orsg[1]};
            `EFR_OFS_ORSG2:    nxt_q.rdat = {24'h000000, q_ff.orsg[2]};
            `EFR_OFS_ORSG3:    nxt_q.rdat = {24'h000000, q_ff.orsg[3]};
            `EFR_OFS_ORSG4:    nxt_q.rdat = {24'h000000, q_ff.orsg[4]};
            `EFR_OFS_ORSG5:    nxt_q.rdat = {24'h000000, q_ff.orsg[5]};
            `EFR_OFS_FUNC:     nxt_q.rdat = {28'h0000000, q_ff.sw_bank, q_ff.char_sel,
                                             q_ff.swap_en};
            `EFR_OFS_STATUS:   nxt_q.rdat = {27'h0, q_ff.sts};
            `EFR_OFS_MASK:     nxt_q.rdat = {27'h0, q_ff.mask};
            `EFR_OFS_STATE:    nxt_q.rdat = {16'h0000, q_ff.trip_o, q_ff.start_o,
                                             1'b0, q_ff.char_eff, q_ff.bank2,
                                             1'b0, q_ff.blk_tr, q_ff.blk_high,
                                             q_ff.blk_low};
            `EFR_OFS_CKSUM_A:  nxt_q.rdat = {cksum(q_ff.orsg[0]), cksum(q_ff.cisg[2]),
                                             cksum(q_ff.cisg[1]), cksum(q_ff.cisg[0])};
            `EFR_OFS_CKSUM_B:  nxt_q.rdat = {cksum(q_ff.orsg[4]), cksum(q_ff.orsg[3]),
                                             cksum(q_ff.orsg[2]), cksum(q_ff.orsg[1])};
            `EFR_OFS_CKSUM_C:  nxt_q.rdat = {24'h000000, cksum(q_ff.orsg[5])};
            `EFR_OFS_DISP_SEL: nxt_q.rdat = {30'h0, q_ff.disp_sel};
            `EFR_OFS_DISP_VAL: nxt_q.rdat = disp_word;
            default:           nxt_q.rdat = 32'h00000000;
         endcase
      end

      // Writes land at the edge where the master sees ack
      if (wr_now) begin
         unique case (byte_adr)
            `EFR_OFS_CISG0:    nxt_q.cisg[0] = wb_dat_i[7:0];
            `EFR_OFS_CISG1:    nxt_q.cisg[1] = wb_dat_i[7:0];
            `EFR_OFS_CISG2:    nxt_q.cisg[2] = wb_dat_i[7:0];
            `EFR_OFS_ORSG0:    nxt_q.orsg[0] = wb_dat_i[7:0];
            `EFR_OFS_ORSG1:    nxt_q.orsg[1] = wb_dat_i[7:0];
            `EFR_OFS_ORSG2:    nxt_q.orsg[2] = wb_dat_i[7:0];
            `EFR_OFS_ORSG3:    nxt_q.orsg[3] = wb_dat_i[7:0];
            `EFR_OFS_ORSG4:    nxt_q.orsg[4] = wb_dat_i[7:0];
            `EFR_OFS_ORSG5:    nxt_q.orsg[5] = wb_dat_i[7:0];
            `EFR_OFS_FUNC: begin
               nxt_q.swap_en = wb_dat_i[`EFR_FN_SWAP_EN];
               nxt_q.char_sel = wb_dat_i[`EFR_FN_CHAR_HI:`EFR_FN_CHAR_LO];
               nxt_q.sw_bank = wb_dat_i[`EFR_FN_SW_BANK];
               // Return bit wins over the bank bit in the same write
               if (wb_dat_i[`EFR_FN_RETURN]) begin
                  nxt_q.sw_bank = 1'b0;
               end
            end
            `EFR_OFS_STATUS:   clr = wb_dat_i[4:0];
            `EFR_OFS_MASK:     nxt_q.mask = wb_dat_i[4:0];
            `EFR_OFS_DISP_SEL: nxt_q.disp_sel = efr_disp_sel_t'(wb_dat_i[1:0]);
            default: begin
            end
         endcase
      end

      // The serial return holds the main bank even with inputs inactive
      if (wr_now && byte_adr == `EFR_OFS_FUNC && wb_dat_i[`EFR_FN_RETURN]) begin
         nxt_q.bank2 = bank_in;
      end
      // Bank event taken after the return so a forced change is seen
      ev[`EFR_EV_BANK] = nxt_q.bank2 ^ q_ff.bank2;

      // Sticky status: a new event beats a same-cycle clear
      nxt_q.sts = (q_ff.sts & ~clr) | ev;
      nxt_q.irq = |(nxt_q.sts & nxt_q.mask);
   end

   // All state but the display digits in one register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q_ff <= '0;
         q_ff.cisg <= {3{`EFR_RST_SG}};
         q_ff.orsg <= {6{`EFR_RST_SG}};
         q_ff.mask <= `EFR_RST_MASK;
         q_ff.disp_sel <= EFR_DISP_U0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Display formatter keeps its digits in its own flops
   efr_disp u_disp (
      .mclk                (mclk),
      .rst                 (rst),
      .disp_sel            (q_ff.disp_sel),
      .resid_voltage_pct   (resid_voltage_pct),
      .neutral_current_pct (neutral_current_pct),
      .phase_angle_deg     (phase_angle_deg),
      .noise_pct           (noise_pct),
      .transient_locating  (transient_locating),
      .digit_hi            (dd_hi),
      .digit_mid           (dd_mid),
      .digit_lo            (dd_lo),
      .digit_minus         (dd_minus),
      .digit_dash          (dd_dash)
   );

   // Outputs straight from flops
   assign wb_dat_o = q_ff.rdat;
   assign wb_ack_o = q_ff.ack;
   assign irq = q_ff.irq;
   assign block_low_set_stage = q_ff.blk_low;
   assign block_high_set_stage = q_ff.blk_high;
   assign block_transient_stage = q_ff.blk_tr;
   assign characteristic_select = q_ff.char_eff;
   assign second_bank_select = q_ff.bank2;
   assign indicator_reset = q_ff.ind_rst;
   assign relay_reset = q_ff.rel_rst;
   assign register_clear = q_ff.reg_clr;
   assign start_outputs = q_ff.start_o;
   assign trip_outputs = q_ff.trip_o;
   assign display_digit_hi = dd_hi;
   assign display_digit_mid = dd_mid;
   assign display_digit_lo = dd_lo;
   assign display_minus = dd_minus;
   assign display_dash = dd_dash;

endmodule
`default_nettype wire

// File: src/efr_cfg.svh
// Constants of the earth-fault control input routing block
`ifndef EFR_CFG_SVH
`define EFR_CFG_SVH

// Register byte offsets on the bus
`define EFR_OFS_CISG0     8'h00
`define EFR_OFS_CISG1     8'h04
`define EFR_OFS_CISG2     8'h08
`define EFR_OFS_ORSG0     8'h0c
`define EFR_OFS_ORSG1     8'h10
`define EFR_OFS_ORSG2     8'h14
`define EFR_OFS_ORSG3     8'h18
`define EFR_OFS_ORSG4     8'h1c
`define EFR_OFS_ORSG5     8'h20
`define EFR_OFS_FUNC      8'h24
`define EFR_OFS_STATUS    8'h28
`define EFR_OFS_MASK      8'h2c
`define EFR_OFS_STATE     8'h30
`define EFR_OFS_CKSUM_A   8'h34
`define EFR_OFS_CKSUM_B   8'h38
`define EFR_OFS_CKSUM_C   8'h3c
`define EFR_OFS_DISP_SEL  8'h40
`define EFR_OFS_DISP_VAL  8'h44

// Switch positions inside a control input switchgroup
`define EFR_SW_BLK_LOW    0
`define EFR_SW_BLK_HIGH   1
`define EFR_SW_BLK_TR     2
`define EFR_SW_SWAP       3
`define EFR_SW_BANK       4
`define EFR_SW_RST_IND    5
`define EFR_SW_RST_REL    6
`define EFR_SW_RST_REG    7

// Function register fields
`define EFR_FN_SWAP_EN    0
`define EFR_FN_CHAR_LO    1
`define EFR_FN_CHAR_HI    2
`define EFR_FN_SW_BANK    3
`define EFR_FN_RETURN     4

// Event bits of the status and mask registers
`define EFR_EV_BANK       0
`define EFR_EV_IND        1
`define EFR_EV_REL        2
`define EFR_EV_REG        3
`define EFR_EV_BLOCK      4
`define EFR_EV_W          5

// Reset values
`define EFR_RST_SG        8'h00
`define EFR_RST_MASK      5'h00

// Display limits and codes
`define EFR_MAX_U0        8'hd2
`define EFR_MAX_I0        8'h8c
`define EFR_MAX_PHI       9'h0b4
`define EFR_MAX_NOISE     8'h06
`define EFR_DIGIT_DASH    4'hf

`endif

// File: src/efr_pkg.sv
// Types of the earth-fault control input routing block
package efr_pkg;

   typedef enum logic [1:0] {
      EFR_DISP_U0    = 2'b00,
      EFR_DISP_I0    = 2'b01,
      EFR_DISP_PHI   = 2'b10,
      EFR_DISP_NOISE = 2'b11
   } efr_disp_sel_t;

   typedef struct packed {
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
      logic       minus;
      logic       dash;
   } efr_disp_state_t;

   typedef struct packed {
      logic            ack;
      logic [31:0]     rdat;
      logic [2:0][7:0] cisg;
      logic [5:0][7:0] orsg;
      logic            swap_en;
      logic [1:0]      char_sel;
      logic            sw_bank;
      efr_disp_sel_t   disp_sel;
      logic [4:0]      sts;
      logic [4:0]      mask;
      logic            irq;
      logic [2:0]      in_prev;
      logic            blk_low;
      logic            blk_high;
      logic            blk_tr;
      logic [1:0]      char_eff;
      logic            bank2;
      logic            ind_rst;
      logic            rel_rst;
      logic            reg_clr;
      logic [3:0]      start_o;
      logic [3:0]      trip_o;
   } efr_state_t;

endpackage

// File: src/efr_disp.sv
// Measured-data display formatter: clamps and converts to three digits
`timescale 1ns/1ps
`default_nettype none
`include "efr_cfg.svh"

module efr_disp (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire efr_pkg::efr_disp_sel_t disp_sel,
   input  wire logic [7:0]             resid_voltage_pct,
   input  wire logic [7:0]             neutral_current_pct,
   input  wire logic signed [8:0]      phase_angle_deg,
   input  wire logic [7:0]             noise_pct,
   input  wire logic                   transient_locating,
   output logic [3:0]                  digit_hi,
   output logic [3:0]                  digit_mid,
   output logic [3:0]                  digit_lo,
   output logic                        digit_minus,
   output logic                        digit_dash
);
   import efr_pkg::*;

   efr_disp_state_t q_ff;
   efr_disp_state_t nxt_q;
   logic [8:0]      mag;
   logic [8:0]      ang_abs;

   // Clamp a value to its display range
   function automatic logic [8:0] clamp(input logic [8:0] v, input logic [8:0] lim);
      clamp = (v > lim) ? lim : v;
   endfunction

   // Magnitude of the phase angle; sign goes to its own segment
   always_comb begin
      ang_abs = phase_angle_deg[8] ? 9'(-phase_angle_deg) : 9'(phase_angle_deg);
   end

   // Pick and format the selected quantity on the right-hand digits
   always_comb begin
      nxt_q = q_ff;
      nxt_q.minus = 1'b0;
      nxt_q.dash = 1'b0;
      unique case (disp_sel)
         EFR_DISP_U0:    mag = clamp({1'b0, resid_voltage_pct}, {1'b0, `EFR_MAX_U0});
         EFR_DISP_I0:    mag = clamp({1'b0, neutral_current_pct}, {1'b0, `EFR_MAX_I0});
         EFR_DISP_PHI: begin
            mag = clamp(ang_abs, `EFR_MAX_PHI);
            nxt_q.minus = phase_angle_deg[8];
         end
         EFR_DISP_NOISE: mag = clamp({1'b0, noise_pct}, {1'b0, `EFR_MAX_NOISE});
      endcase
      nxt_q.d2 = 4'(mag / 9'h064);
      nxt_q.d1 = 4'((mag / 9'h00a) % 9'h00a);
      nxt_q.d0 = 4'(mag % 9'h00a);
      // Dash pattern on the noise display while the transient stage is locating a fault
      if (disp_sel == EFR_DISP_NOISE && transient_locating) begin
         nxt_q.d2 = `EFR_DIGIT_DASH;
         nxt_q.d1 = `EFR_DIGIT_DASH;
         nxt_q.d0 = `EFR_DIGIT_DASH;
         nxt_q.dash = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign digit_hi = q_ff.d2;
   assign digit_mid = q_ff.d1;
   assign digit_lo = q_ff.d0;
   assign digit_minus = q_ff.minus;
   assign digit_dash = q_ff.dash;

endmodule
`default_nettype wire

// File: sim/efr_far.sv
// Far-side model: control input contacts and latching output relays
`timescale 1ns/1ps
`default_nettype none
module efr_far (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [2:0] cmd,
   input  wire logic [3:0] trip_outputs,
   input  wire logic       relay_reset,
   output logic            blocking_input_one,
   output logic            blocking_input_two,
   output logic            remote_reset_input,
   output logic [3:0]      latched_relays
);
   // Contacts move one edge after a command, like a clocked field input
   always_ff @(posedge mclk) begin
      {remote_reset_input, blocking_input_two, blocking_input_one} <= rst ? 3'h0 : cmd;
   end
   // Relays hold once tripped until the device pulses a relay reset
   always_ff @(posedge mclk) begin
      if (rst || relay_reset) begin
         latched_relays <= 4'h0;
      end else begin
         latched_relays <= latched_relays | trip_outputs;
      end
   end
endmodule
`default_nettype wire

// File: sim/efr_top_sva.sv
// Port assertions of the earth-fault input routing block
`timescale 1ns/1ps
`default_nettype none
module efr_chk (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       blocking_input_one,
   input wire logic       blocking_input_two,
   input wire logic       remote_reset_input,
   input wire logic [2:0] stage_start,
   input wire logic [2:0] stage_trip,
   input wire logic       transient_activated,
   input wire logic       transient_locating,
   input wire logic       block_low_set_stage,
   input wire logic       block_high_set_stage,
   input wire logic       block_transient_stage,
   input wire logic       indicator_reset,
   input wire logic       relay_reset,
   input wire logic       register_clear,
   input wire logic [3:0] start_outputs,
   input wire logic [3:0] trip_outputs,
   input wire logic [3:0] display_digit_hi,
   input wire logic [3:0] display_digit_mid,
   input wire logic [3:0] display_digit_lo,
   input wire logic       display_dash
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Control inputs gathered so edge tests stay short
   logic [2:0] ins;
   assign ins = {remote_reset_input, blocking_input_two, blocking_input_one};
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_edge; ($past(ins) & ~$past(ins, 2)) != 3'h0; endsequence
   property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   property p_ind; indicator_reset |-> s_edge; endproperty
   property p_rel; relay_reset |-> indicator_reset; endproperty
   property p_reg; register_clear |-> relay_reset && indicator_reset; endproperty
   property p_trs; transient_activated |=> !block_transient_stage; endproperty
   property p_blk; block_low_set_stage || block_high_set_stage |-> $past(ins) != 3'h0;
   endproperty
   property p_btr; block_transient_stage |-> $past(ins) != 3'h0; endproperty
   property p_rte; (start_outputs != 4'h0 || trip_outputs != 4'h0)
      |-> $past(stage_start | stage_trip) != 3'h0; endproperty
   property p_dash; display_dash |-> $past(transient_locating)
      && {display_digit_hi, display_digit_mid, display_digit_lo} == 12'hfff; endproperty
   property p_bcd; !display_dash |-> display_digit_hi <= 4'h2
      && display_digit_mid <= 4'h9 && display_digit_lo <= 4'h9; endproperty
   a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
   a_ind: assert property (p_ind) else $error("indicator reset without input edge");
   a_rel: assert property (p_rel) else $error("relay reset alone");
   a_reg: assert property (p_reg) else $error("register clear alone");
   a_trs: assert property (p_trs) else $error("running transient stage blocked");
   a_blk: assert property (p_blk) else $error("stage blocked with inputs idle");
   a_btr: assert property (p_btr) else $error("transient blocked, inputs idle");
   a_rte: assert property (p_rte) else $error("output without stage signal");
   a_dash: assert property (p_dash) else $error("dash display wrong");
   a_bcd: assert property (p_bcd) else $error("display digit out of range");
endmodule
bind efr_top efr_chk efr_chk_i (.*);
`default_nettype wire

// File: sim/efr_top_bench.sv
// Self-checking bench of the earth-fault input routing block
`timescale 1ns/1ps
`default_nettype none
module efr_top_bench;
   import efr_pkg::*;
   logic              mclk, rst, cyc, stb, we, ack, irq, tra, loc, b1, b2, rri;
   logic              bl, bh, bt, bank, ir, rr, rc, dd, dm;
   logic [1:0]        chr;
   logic [2:0]        ci, ss, st, seen;
   logic [3:0]        so, to, dh, dmd, dl, lat;
   logic [7:0]        adr, u0, i0, nz;
   logic [7:0]        g [6];
   logic signed [8:0] ph;
   logic [31:0]       dat, rdat, r;
   int                n_fail, comparisons, seed, x;
   int                lim [4] = '{210, 140, 180, 6};
   efr_top efr_top_i (.mclk, .rst, .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .irq,
      .blocking_input_one(b1), .blocking_input_two(b2), .remote_reset_input(rri),
      .stage_start(ss), .stage_trip(st), .transient_activated(tra), .resid_voltage_pct(u0),
      .neutral_current_pct(i0), .phase_angle_deg(ph), .noise_pct(nz), .transient_locating(loc),
      .block_low_set_stage(bl), .block_high_set_stage(bh), .block_transient_stage(bt),
      .characteristic_select(chr), .second_bank_select(bank), .indicator_reset(ir),
      .relay_reset(rr), .register_clear(rc), .start_outputs(so), .trip_outputs(to),
      .display_digit_hi(dh), .display_digit_mid(dmd), .display_digit_lo(dl),
      .display_minus(dm), .display_dash(dd));
   efr_far efr_far_i (.mclk, .rst, .cmd(ci), .trip_outputs(to), .relay_reset(rr),
      .blocking_input_one(b1), .blocking_input_two(b2), .remote_reset_input(rri),
      .latched_relays(lat));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      comparisons++;
      if (v !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", s, e, v);
      end
   endtask
   // One classic cycle, bounded wait
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      {cyc, stb} <= 2'b00;
      if (n >= 20) chk("ack", 1, 0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
      wb(a, 1'b0, 32'h0);
      chk(s, e, r);
   endtask
   task automatic drv(input logic [2:0] c);
      @(posedge mclk);
      ci <= c;
      repeat (3) @(negedge mclk);
   endtask
   function automatic logic [7:0] cks(logic [7:0] b);
      cks = 8'h0;
      for (int i = 0; i < 8; i++) if (b[i]) cks += 8'(1 << i);
   endfunction
   function automatic logic [7:0] route(logic [2:0] s, logic [2:0] t);
      route = 8'h0;
      for (int k = 0; k < 6; k++) if (k % 2 ? t[k/2] : s[k/2]) route |= g[k];
   endfunction
   function automatic logic [13:0] dexp(int s, int v, logic l);
      logic m;
      if (s == 3 && l) return 14'h2fff;
      m = (s == 2 && v < 0);
      if (m) v = -v;
      if (v > lim[s]) v = lim[s];
      return {1'b0, m, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   task automatic finish_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      finish_test;
   end
   initial begin
      {seed, n_fail, comparisons, rst, cyc, stb, we, tra, loc} = {32'd82, 64'd0, 6'b100000};
      {adr, dat, ci, ss, st, u0, i0, nz, ph} = '0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h00, 0, "cisg0");
      rd(8'h2c, 0, "mask");
      rd(8'h48, 0, "unmapped");
      for (int k = 0; k < 6; k++) g[k] = 8'($random(seed));
      for (int k = 0; k < 9; k++) wb(8'(4 * k), 1'b1, {24'h0, g[k < 3 ? k : k - 3]});
      rd(8'h34, {cks(g[0]), cks(g[2]), cks(g[1]), cks(g[0])}, "cksum_a");
      rd(8'h38, {cks(g[4]), cks(g[3]), cks(g[2]), cks(g[1])}, "cksum_b");
      rd(8'h3c, {24'h0, cks(g[5])}, "cksum_c");
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         {ss, st} <= 6'($random(seed));
         repeat (3) @(negedge mclk);
         chk("route", route(ss, st), {to, so});
      end
      {ss, st} <= 6'h0;
      $display("routing test done");
      for (int k = 0; k < 3; k++) wb(8'(4 * k), 1'b1, 32'(1 << k));
      for (int k = 0; k < 3; k++) begin
         drv(3'(1 << k));
         chk("block", 1 << k, {bt, bh, bl});
      end
      tra <= 1'b1;
      drv(3'h4);
      chk("activated", 0, bt);
      tra <= 1'b0;
      wb(8'h04, 1'b1, 32'h03);
      drv(3'h2);
      chk("any input", 3, {bh, bl});
      wb(8'h00, 1'b1, 32'h18);
      for (int k = 0; k < 8; k++) begin
         wb(8'h24, 1'b1, 32'(k / 2 * 2 + 1));
         drv(3'(k % 2));
         chk("swap", {k % 2 == 1, 2'(k / 2) ^ 2'(k % 2)}, {bank, chr});
      end
      wb(8'h24, 1'b1, 32'h02);
      drv(3'h1);
      chk("swap off", 3'b101, {bank, chr});
      wb(8'h00, 1'b1, 32'h00);
      drv(3'h1);
      chk("bank off", 0, bank);
      wb(8'h24, 1'b1, 32'h08);
      drv(3'h0);
      chk("sw bank", 1, bank);
      wb(8'h24, 1'b1, 32'h10);
      drv(3'h0);
      chk("return", 0, bank);
      $display("control test done");
      wb(8'h28, 1'b1, 32'h1f);
      wb(8'h2c, 1'b1, 32'h00);
      for (int j = 5; j < 8; j++) begin
         wb(8'h08, 1'b1, 32'(1 << j));
         seen = 3'h0;
         @(posedge mclk);
         ci <= 3'h4;
         repeat (5) @(negedge mclk) seen |= {rc, rr, ir};
         drv(3'h0);
         chk("resets", j == 5 ? 1 : j == 6 ? 3 : 7, seen);
      end
      chk("relays", 0, lat);
      chk("masked irq", 0, irq);
      rd(8'h28, 32'h0e, "status");
      wb(8'h2c, 1'b1, 32'h0e);
      drv(3'h0);
      chk("irq", 1, irq);
      wb(8'h28, 1'b1, 32'h0e);
      drv(3'h0);
      chk("irq clear", 0, irq);
      $display("reset test done");
      for (int k = 0; k < 12; k++) begin
         wb(8'h40, 1'b1, 32'(k % 4));
         @(posedge mclk);
         {u0, i0} <= 16'($random(seed));
         nz <= 8'($random(seed) & 7);
         ph <= 9'($random(seed) % 256);
         loc <= (k > 7);
         repeat (3) @(negedge mclk);
         x = (k % 4 == 0) ? u0 : (k % 4 == 1) ? i0 : (k % 4 == 2) ? int'(ph) : nz;
         chk("display", dexp(k % 4, x, loc), {dd, dm, dh, dmd, dl});
      end
      $display("display test done");
      finish_test;
   end
endmodule
`default_nettype wire
